// ### include/wdt_pkg.sv
// Constants, register map and decode helpers for the watchdog block.
// Assumes a single 10 MHz system clock and a 32-bit Avalon-MM slave port.
//
// Contract
// - Counter is 14 bits, decrements per tick
// - Period field picks 03FF, 0FFF, 1FFF, 3FFF
// - Window field picks 25, 50, 75, 100 percent
// - Percent measured against whole count interval
// - CPU clock normally, slow oscillator when protected
// - Start on reset or on start write
// - Start option decides run or stop after reset
// - Stop/wait halt counter unless protected
// - Reload on reset, valid refresh, underflow
// - Underflow gives interrupt or reset; protected resets
// - Initial value from second option byte
// - Protect option sets protection after reset
// - Option byte erased reads FF, else programmed
// - Prescaler ahead of counter has selectable ratio
// - Refresh is write 00h then FFh
// - Prescaler select: 0 is /16, 1 is /128
// - Protect bit set by 0 then 1, sticky
// - Interrupt/reset select set to 1 sticks
package wdt_pkg;

  localparam int ADDR_W = 18;
  localparam int CNT_W = 14;
  localparam int PRE_W = 7;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [17:0] OFF_REFRESH = 18'h00000;
  localparam logic [17:0] OFF_START = 18'h00004;
  localparam logic [17:0] OFF_CTRL = 18'h00008;
  localparam logic [17:0] OFF_PROTECT = 18'h0000C;
  localparam logic [17:0] OFF_MODE = 18'h00010;
  localparam logic [17:0] OFF_PRIMARY_OPT = 18'h00014;
  localparam logic [17:0] IDX_WDT_OPT = 18'h0FFDB;
  localparam logic [17:0] OFF_WDT_OPT = 18'(IDX_WDT_OPT << 2);

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int BIT_PRESCALER_SEL = 7;
  localparam int BIT_PROTECT = 7;
  localparam int BIT_IRQ_RST = 2;
  localparam int BIT_START_CFG = 0;
  localparam int BIT_PROTECT_CFG = 7;
  localparam int POS_UFS = 0;
  localparam int POS_RCS = 2;
  localparam logic RST_PRESCALER_SEL = 1'b0;
  localparam logic RST_IRQ_RST = 1'b0;
  localparam logic [7:0] OPT_ERASED = 8'hFF;

  localparam logic [7:0] REFRESH_FIRST = 8'h00;
  localparam logic [7:0] REFRESH_SECOND = 8'hFF;
  localparam logic [6:0] DIV_LO_LAST = 7'h0F;
  localparam logic [6:0] DIV_HI_LAST = 7'h7F;

  localparam logic [13:0] INIT_P0 = 14'h03FF;
  localparam logic [13:0] INIT_P1 = 14'h0FFF;
  localparam logic [13:0] INIT_P2 = 14'h1FFF;
  localparam logic [13:0] INIT_P3 = 14'h3FFF;

  typedef enum logic {SEQ_IDLE, SEQ_ARMED} seq_t;

  function automatic logic [13:0] period_init(input logic [1:0] ufs);
    case (ufs)
      2'h0: period_init = INIT_P0;
      2'h1: period_init = INIT_P1;
      2'h2: period_init = INIT_P2;
      default: period_init = INIT_P3;
    endcase
  endfunction

endpackage

// ### include/tick_if.sv
// Carrier between the watchdog core and its prescaler.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface tick_if;
  logic src_tick;
  logic div_sel;
  logic run;
  logic tick;
  modport ctrl (output src_tick, output div_sel, output run, input tick);
  modport presc (input src_tick, input div_sel, input run, output tick);
endinterface
`default_nettype wire

// ### src/wdt_prescaler.sv
// Count-source prescaler: passes every 16th or 128th source tick.
// Assumes source ticks are one-cycle enables on the system clock.
`timescale 1ns/100ps
`default_nettype none
module wdt_prescaler (
  input wire logic sys_clk,
  input wire logic rst_n,
  tick_if.presc pio
);
  import wdt_pkg::*;

  logic [PRE_W-1:0] cnt;
  logic [PRE_W-1:0] last;

  assign last = pio.div_sel ? DIV_HI_LAST : DIV_LO_LAST;

  assign pio.tick = pio.run && pio.src_tick && (cnt == last);

  // Held at zero while halted so a restart always gets a full prescale
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (!pio.run) begin
      cnt <= '0;
    end else if (pio.src_tick) begin
      cnt <= (cnt == last) ? '0 : PRE_W'(cnt + 1'b1);
    end
  end

endmodule
`default_nettype wire

// ### src/wdt_core.sv
// Watchdog timer: 14-bit down-counter, option bytes, Avalon-MM slave.
// Assumes lso_tick is a one-cycle enable from the low-speed oscillator
// and that stop_mode / wait_mode are synchronous levels.
`timescale 1ns/100ps
`default_nettype none
module wdt_core #(
  parameter logic [7:0] WDT_OPT_INIT = wdt_pkg::OPT_ERASED,
  parameter logic [7:0] PRIMARY_OPT_INIT = wdt_pkg::OPT_ERASED
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [wdt_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic lso_tick,
  input wire logic stop_mode,
  input wire logic wait_mode,
  output logic wdt_irq,
  output logic wdt_reset_req,
  output logic wdt_running
);
  import wdt_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [CNT_W-1:0] count;
  logic running;
  logic post_reset;
  logic protect_mode_ctrl;
  logic protect_armed;
  logic irq_or_reset_select;
  logic prescaler_select;
  logic [7:0] watchdog_option_byte;
  logic [7:0] primary_option_byte;
  seq_t seq;

  logic req;
  logic wr_en;
  logic [7:0] wbyte;
  logic [1:0] ufs;
  logic [1:0] rcs;
  logic [CNT_W-1:0] init_val;
  logic halted;
  logic tick;
  logic underflow;
  logic refresh_hit;
  logic in_window;

  tick_if pio ();

  wdt_prescaler u_prescaler (
    .sys_clk (sys_clk),
    .rst_n (rst_n),
    .pio (pio)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Final part of the interval; the span is a power of two so the
  // quarter steps are exact
  function automatic logic in_refresh_window(
    input logic [13:0] cnt,
    input logic [1:0] ufs_f,
    input logic [1:0] rcs_f
  );
    logic [14:0] span;
    logic [16:0] limit;
    span = 15'({1'b0, period_init(ufs_f)} + 15'h0001);
    limit = 17'(span >> 2) * 17'({15'h0000, rcs_f} + 17'h00001);
    in_refresh_window = ({3'h0, cnt} < limit);
  endfunction

  // Six-bit view of the counter, shifted to suit the period
  function automatic logic [5:0] count_view(
    input logic [13:0] cnt,
    input logic [1:0] ufs_f
  );
    case (ufs_f)
      2'h0: count_view = cnt[5:0];
      2'h1: count_view = cnt[7:2];
      2'h2: count_view = cnt[8:3];
      default: count_view = cnt[9:4];
    endcase
  endfunction

  function automatic logic [7:0] reg_read(input logic [17:0] a);
    case (a)
      OFF_CTRL: reg_read = {prescaler_select, 1'b0,
                            count_view(count, ufs)};
      OFF_PROTECT: reg_read = {protect_mode_ctrl, 7'h00};
      OFF_MODE: reg_read = {5'h00, irq_or_reset_select, 2'h0};
      OFF_PRIMARY_OPT: reg_read = primary_option_byte;
      OFF_WDT_OPT: reg_read = watchdog_option_byte;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  // One wait state on every access; write-only and unmapped words
  // read as zero, and unmapped words ignore writes
  assign req = avs_read || avs_write;
  assign wr_en = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h000000, reg_read(avs_address)};
    end
  end

  // ------------------------------------------------------------
  // Option bytes
  // ------------------------------------------------------------
  // Held as the programmed flash image; a write models reprogramming,
  // but reset reloads the parameter value, so a written start/protect choice never acts
  // erased image
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_option_byte <= WDT_OPT_INIT;
      primary_option_byte <= PRIMARY_OPT_INIT;
    end else if (wr_en) begin
      if (avs_address == OFF_WDT_OPT) begin
        watchdog_option_byte <= wbyte;
      end
      if (avs_address == OFF_PRIMARY_OPT) begin
        primary_option_byte <= wbyte;
      end
    end
  end

  assign ufs = watchdog_option_byte[POS_UFS +: 2];
  assign rcs = watchdog_option_byte[POS_RCS +: 2];

  assign init_val = period_init(ufs);

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_select <= RST_PRESCALER_SEL;
    end else if (wr_en && avs_address == OFF_CTRL) begin
      prescaler_select <= wbyte[BIT_PRESCALER_SEL];
    end
  end

  // First cycle after release; straps are sampled here, not in reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      post_reset <= 1'b1;
    end else begin
      post_reset <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      protect_mode_ctrl <= 1'b0;
      protect_armed <= 1'b0;
    end else if (post_reset) begin
      protect_mode_ctrl <= !primary_option_byte[BIT_PROTECT_CFG];
      protect_armed <= 1'b0;
    end else if (wr_en && avs_address == OFF_PROTECT) begin
      if (wbyte[BIT_PROTECT] && protect_armed) begin
        protect_mode_ctrl <= 1'b1;
      end
      protect_armed <= !wbyte[BIT_PROTECT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_or_reset_select <= RST_IRQ_RST;
    end else if (protect_mode_ctrl) begin
      irq_or_reset_select <= 1'b1;
    end else if (wr_en && avs_address == OFF_MODE
                 && wbyte[BIT_IRQ_RST]) begin
      irq_or_reset_select <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  // start on write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
    end else if (post_reset) begin
      running <= !primary_option_byte[BIT_START_CFG];
    end else if (wr_en && avs_address == OFF_START) begin
      running <= 1'b1;
    end
  end

  assign halted = !protect_mode_ctrl && (stop_mode || wait_mode);

  assign pio.src_tick = protect_mode_ctrl ? lso_tick : 1'b1;
  assign pio.div_sel = prescaler_select;
  assign pio.run = running && !halted;
  assign tick = pio.tick;

  // ------------------------------------------------------------
  // Refresh sequence
  // ------------------------------------------------------------
  // Any other byte, or the second byte without the first, drops
  // the sequence so a stray write cannot complete a refresh
  // 00h then FFh
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq <= SEQ_IDLE;
    end else if (wr_en && avs_address == OFF_REFRESH) begin
      case (seq)
        SEQ_IDLE: begin
          seq <= (wbyte == REFRESH_FIRST) ? SEQ_ARMED : SEQ_IDLE;
        end
        SEQ_ARMED: begin
          seq <= (wbyte == REFRESH_FIRST) ? SEQ_ARMED : SEQ_IDLE;
        end
        default: begin
          seq <= SEQ_IDLE;
        end
      endcase
    end
  end

  assign in_window = in_refresh_window(count, ufs, rcs);

  assign refresh_hit = wr_en && avs_address == OFF_REFRESH
                       && seq == SEQ_ARMED
                       && wbyte == REFRESH_SECOND
                       && running && in_window;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  assign underflow = tick && count == '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= INIT_P3;
    end else if (post_reset || refresh_hit || underflow) begin
      count <= init_val;
    end else if (tick) begin
      count <= CNT_W'(count - 1'b1);
    end
  end

  // ------------------------------------------------------------
  // Underflow action
  // ------------------------------------------------------------
  // interrupt or reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_irq <= 1'b0;
      wdt_reset_req <= 1'b0;
    end else begin
      wdt_irq <= underflow && !irq_or_reset_select
                 && !protect_mode_ctrl;
      wdt_reset_req <= underflow
                       && (irq_or_reset_select || protect_mode_ctrl);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_running <= 1'b0;
    end else begin
      wdt_running <= running && !halted;
    end
  end

endmodule
`default_nettype wire

// ### bench/wdt_core_monitor.sv
// Checker for the watchdog core: bus wait state, underflow pulses, modes.
// Assumes it is bound into wdt_core and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module wdt_core_monitor
  import wdt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic lso_tick,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic wdt_irq,
  input wire logic wdt_reset_req,
  input wire logic wdt_running
);
  // ----------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------
  // Fastest underflow: 1024 ticks of divide-by-16 on the system clock
  localparam int MIN_GAP = 16380;
  logic [14:0] gap;
  logic mode_set;
  logic wr_done;
  assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= '0;
    end else if (wdt_irq || wdt_reset_req) begin
      gap <= '0;
    end else if (gap != 15'h7FFF) begin
      gap <= gap + 15'h0001;
    end
  end
  // Set-only, like the select bit it shadows
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_set <= 1'b0;
    end else if (wr_done && avs_address == OFF_MODE
                 && avs_writedata[BIT_IRQ_RST]) begin
      mode_set <= 1'b1;
    end
  end
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wait_one_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait state");
  wait_short_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  irq_pulse_a: assert property (wdt_irq |=> !wdt_irq)
    else $error("interrupt longer than one cycle");
  rst_pulse_a: assert property (
    wdt_reset_req |=> !wdt_reset_req)
    else $error("reset request longer than one cycle");
  one_action_a: assert property (
    !(wdt_irq && wdt_reset_req))
    else $error("interrupt and reset request together");
  needs_run_a: assert property (
    (wdt_irq || wdt_reset_req) |-> $past(wdt_running, 2))
    else $error("underflow while counter not running");
  min_gap_a: assert property (
    (wdt_irq || wdt_reset_req) |-> gap >= MIN_GAP)
    else $error("underflow sooner than the shortest period");
  irq_mode_a: assert property (wdt_irq |-> !mode_set)
    else $error("interrupt after reset action was selected");
  mode_read_a: assert property (
    avs_read && !avs_waitrequest && avs_address == OFF_MODE && mode_set
    |-> avs_readdata[BIT_IRQ_RST])
    else $error("reset select bit read back as zero");
  irq_seen_c: cover property (wdt_irq);
  rst_seen_c: cover property (wdt_reset_req);
  refresh_c: cover property (wr_done && avs_address == OFF_REFRESH);
endmodule
bind wdt_core wdt_core_monitor mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .lso_tick(lso_tick), .stop_mode(stop_mode), .wait_mode(wait_mode),
  .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req),
  .wdt_running(wdt_running)
);
`default_nettype wire

// ### bench/wdt_core_test.sv
// Self-checking bench for the watchdog core over its Avalon-MM port.
// Assumes wdt_pkg, the design and the bound monitor are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
  checks_done++; \
  if ((gt) !== (ex)) begin \
    miscompares++; \
    $display("unexpected %s: expected %h seen %h", nm, ex, gt); \
  end \
end
module wdt_core_test;
  import wdt_pkg::*;
  // Shortest period and 25 percent window keep unprotected underflows near 16k cycles
  localparam logic [7:0] OPT = 8'hF0;
  localparam int UF = 16 * 1024;
  localparam int LIMIT = 95000;
  localparam logic [17:0] RA [7] = '{OFF_CTRL, OFF_WDT_OPT, OFF_MODE,
    OFF_PROTECT, OFF_PRIMARY_OPT, OFF_REFRESH, 18'h00040};
  localparam logic [7:0] RV [7] = '{8'h3F, OPT, 8'h00, 8'h00, 8'hFF,
    8'h00, 8'h00};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic lso_tick = 1'b0;
  logic lso_on = 1'b0;
  logic stop_mode = 1'b0;
  logic wait_mode = 1'b0;
  logic wdt_irq;
  logic wdt_reset_req;
  logic wdt_running;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int t0;
  wdt_core #(.WDT_OPT_INIT(OPT), .PRIMARY_OPT_INIT(8'hFF)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lso_tick(lso_tick), .stop_mode(stop_mode), .wait_mode(wait_mode),
    .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req),
    .wdt_running(wdt_running)
  );
  // ----------------------------------------------------------
  // Clock, slow oscillator ticks and hang guard
  // ----------------------------------------------------------
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (lso_on) begin
      lso_tick <= ~lso_tick;
    end
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      summarize();
    end
  end
  // ----------------------------------------------------------
  // Bus and report tasks
  // ----------------------------------------------------------
  task automatic bus(input logic wr, input logic [17:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Idle edge so the next call never re-drives in this time step
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [17:0] a,
                    input logic [7:0] ex);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(nm, {24'h000000, ex}, q)
  endtask
  task automatic await(input logic rst, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((rst ? wdt_reset_req : wdt_irq) !== 1'b1 && n < lim);
  endtask
  task automatic note(input string s);
    $display("test %s ended, mismatches so far %0d", s, miscompares);
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 7; i++) begin
      rd("reset value", RA[i], RV[i]);
    end
    `CHK("idle running", 1'b0, wdt_running)
    wr(OFF_WDT_OPT, 8'hFC);
    rd("option byte", OFF_WDT_OPT, 8'hFC);
    wr(OFF_WDT_OPT, OPT);
    wr(OFF_CTRL, 8'h80);
    rd("prescaler select", OFF_CTRL, 8'hBF);
    wr(OFF_CTRL, 8'h00);
    note("registers");
    wr(OFF_START, 8'h5A);
    t0 = cycles;
    repeat (2) @(posedge sys_clk);
    `CHK("started", 1'b1, wdt_running)
    // Refresh right after start lies outside the window and must not count
    wr(OFF_REFRESH, 8'h00);
    wr(OFF_REFRESH, 8'hFF);
    await(1'b0, 17000);
    `CHK("interrupt", 1'b1, wdt_irq)
    `CHK("first period", 1'b1,
         logic'((cycles - t0) inside {[UF-44:UF+46]}))
    note("underflow");
    stop_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("stop halts", 1'b0, wdt_running)
    stop_mode <= 1'b0;
    wait_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("wait halts", 1'b0, wdt_running)
    wait_mode <= 1'b0;
    repeat (12800) @(posedge sys_clk);
    wr(OFF_REFRESH, 8'h00);
    wr(OFF_REFRESH, 8'h55);
    wr(OFF_REFRESH, 8'hFF);
    wr(OFF_REFRESH, 8'h00);
    wr(OFF_REFRESH, 8'hFF);
    t0 = cycles;
    await(1'b0, 17000);
    `CHK("refreshed period", 1'b1,
         logic'((cycles - t0) inside {[UF-44:UF+46]}))
    note("refresh");
    wr(OFF_PROTECT, 8'h00);
    wr(OFF_PROTECT, 8'h80);
    wr(OFF_PROTECT, 8'h00);
    rd("protect", OFF_PROTECT, 8'h80);
    rd("forced reset", OFF_MODE, 8'h04);
    wr(OFF_MODE, 8'h04);
    wr(OFF_MODE, 8'h00);
    rd("mode sticky", OFF_MODE, 8'h04);
    lso_on <= 1'b1;
    stop_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("protected run", 1'b1, wdt_running)
    await(1'b1, 40000);
    `CHK("reset request", 1'b1, wdt_reset_req)
    `CHK("no interrupt", 1'b0, wdt_irq)
    note("protection");
    summarize();
  end
endmodule
`default_nettype wire
